// ===== rtl/wtg_consts.vh
`ifndef WTG_CONSTS_VH
`define WTG_CONSTS_VH

// Register addresses on the plain register port.
`define WTG_ADDR_W          4
`define WTG_ADDR_MODE       4'h0
`define WTG_ADDR_KEY        4'h1
`define WTG_ADDR_IRQ_STS    4'h2
`define WTG_ADDR_IRQ_MASK   4'h3

// Key register values.
`define WTG_KEY_VALUE       8'hAC
`define WTG_KEY_READBACK    8'h9A

// Mode register layout and reset value.
`define WTG_MODE_RESET      8'h67
`define WTG_MODE_FIX_MSB    7
`define WTG_MODE_FIX_LSB    5
`define WTG_MODE_FIX_VAL    3'h3
`define WTG_MODE_STOP_BIT   4
`define WTG_MODE_SEL_MSB    2
`define WTG_MODE_SEL_LSB    0
`define WTG_SEL_W           3
`define WTG_SEL_MAX         3'h7

// Interrupt status bit positions.
`define WTG_IRQ_W           4
`define WTG_IRQ_OVF         0
`define WTG_IRQ_BADKEY      1
`define WTG_IRQ_BITOP       2
`define WTG_IRQ_REWRITE     3

// Counter geometry: overflow period is 2^(SEL_BASE + sel) source ticks.
`define WTG_CNT_W           17
`define WTG_SEL_BASE        10

`endif

// ===== rtl/wtg_counter.v
`timescale 1ns/1ps
`include "wtg_consts.vh"

// Watchdog up-counter with selectable overflow period.
module wtg_counter #(
   parameter CNT_W    = `WTG_CNT_W,
   parameter SEL_BASE = `WTG_SEL_BASE
) (
   input  wire                  mclk,     // System clock.
   input  wire                  reset_n,  // Synchronous reset, active low.
   input  wire                  ce,       // Clock enable.
   input  wire                  advance,  // One source tick while running.
   input  wire                  clear,    // Clear count to zero.
   input  wire [`WTG_SEL_W-1:0] sel,      // Overflow period select.
   output reg                   ovf,      // One-cycle overflow pulse.
   output reg  [CNT_W-1:0]      count     // Current count.
);

   wire [CNT_W-1:0] top;

   // Terminal count: 2^(SEL_BASE+sel)-1, or zero once SEL_BASE+sel exceeds the counter width.
   assign top = {CNT_W{1'b1}} >> (CNT_W - SEL_BASE - sel);

   // Count holds its value whenever advance and clear are both low, so a pause keeps it.
   always @(posedge mclk)
   begin
      if (!reset_n)
      begin
         count <= {CNT_W{1'b0}};
         ovf   <= 1'b0;
      end
      else if (ce)
      begin
         ovf <= 1'b0;
         if (clear)
            count <= {CNT_W{1'b0}};
         else if (advance)
         begin
            if (count == top)
            begin
               count <= {CNT_W{1'b0}};
               ovf   <= 1'b1;
            end
            else
               count <= count + {{(CNT_W-1){1'b0}}, 1'b1};
         end
      end
   end

endmodule

// ===== rtl/wtg_top.v
// Local design decisions: strobed register access and the register addresses.
`timescale 1ns/1ps
`include "wtg_consts.vh"

module wtg_top #(
   parameter CNT_W = `WTG_CNT_W
) (
   input  wire                  mclk,          // System clock, 100 MHz.
   input  wire                  reset_n,       // Synchronous reset, active low.
   input  wire                  ce,            // Clock enable, freezes all state.
   input  wire [`WTG_ADDR_W-1:0] reg_addr,     // Register address.
   input  wire [7:0]            reg_wdata,     // Write data.
   input  wire                  reg_wr,        // Full-byte write strobe.
   input  wire                  reg_bitop,     // Single-bit manipulation strobe.
   input  wire                  reg_rd,        // Read strobe.
   output reg  [7:0]            reg_rdata,     // Read data, cycle after reg_rd.
   input  wire                  opt_stoppable, // Option strap: oscillator stoppable.
   input  wire                  osc_tick,      // Internal oscillator tick.
   input  wire                  cpu_halt,      // Processor in HALT.
   input  wire                  cpu_stop,      // Processor in STOP.
   output reg                   wdt_reset,     // Internal reset request, level.
   output wire                  irq,           // Interrupt, level.
   output wire [CNT_W-1:0]      wdt_count      // Current count.
);

   // Address decode shared by write and read paths.
   function hit;
      input [`WTG_ADDR_W-1:0] a;
      input [`WTG_ADDR_W-1:0] b;
      begin
         hit = (a == b);
      end
   endfunction

   reg                    opt_done_r;
   reg                    stoppable_r;
   reg  [7:0]             wdt_mode_reg_r;
   reg                    mode_written_r;
   reg                    stop_latched_r;
   reg                    pend_r;
   reg  [`WTG_IRQ_W-1:0]  sts_r;
   reg  [`WTG_IRQ_W-1:0]  mask_r;
   reg  [`WTG_IRQ_W-1:0]  sts_nxt;
   wire                   src_run;
   wire                   ovf;
   wire                   key_wr;
   wire                   key_bad;
   wire                   key_bit;
   wire                   mode_rewrite;
   wire                   mode_first;
   wire                   cause;
   wire [`WTG_IRQ_W-1:0]  ev;
   wire [`WTG_SEL_W-1:0]  sel;

   // Strobes decoded against the register map.
   assign key_wr       = reg_wr && hit(reg_addr, `WTG_ADDR_KEY);
   assign key_bad      = key_wr && (reg_wdata != `WTG_KEY_VALUE);
   assign key_bit      = reg_bitop && hit(reg_addr, `WTG_ADDR_KEY);
   assign mode_first   = reg_wr && hit(reg_addr, `WTG_ADDR_MODE) && !mode_written_r;
   assign mode_rewrite = reg_wr && hit(reg_addr, `WTG_ADDR_MODE) && mode_written_r;
   assign sel          = wdt_mode_reg_r[`WTG_MODE_SEL_MSB:`WTG_MODE_SEL_LSB];

   // Source clock runs always in the fixed option, else until stopped or paused.
   assign src_run = !stoppable_r ||
                    (!stop_latched_r && !cpu_halt && !cpu_stop);

   // Any cause of internal reset.
   assign cause = key_bad || key_bit || mode_rewrite || ovf;
   assign ev    = {mode_rewrite, key_bit, key_bad, ovf};

   // Option strap is caught on the first enabled cycle after reset release.
   always @(posedge mclk)
   begin
      if (!reset_n)
      begin
         opt_done_r  <= 1'b0;
         stoppable_r <= 1'b0;
      end
      else if (ce && !opt_done_r)
      begin
         opt_done_r  <= 1'b1;
         stoppable_r <= opt_stoppable;
      end
   end

   // Mode register: one byte write accepted; bitwise accesses are not decoded.
   always @(posedge mclk)
   begin
      if (!reset_n)
      begin
         wdt_mode_reg_r <= `WTG_MODE_RESET;
         mode_written_r <= 1'b0;
         stop_latched_r <= 1'b0;
      end
      else if (ce)
      begin
         if (mode_first)
         begin
            mode_written_r <= 1'b1;
            if (stoppable_r)
            begin
               wdt_mode_reg_r <= reg_wdata;
               if (reg_wdata[`WTG_MODE_STOP_BIT])
                  stop_latched_r <= 1'b1;
            end
            else if (reg_wdata[`WTG_MODE_FIX_MSB:`WTG_MODE_FIX_LSB] == `WTG_MODE_FIX_VAL
                     && !reg_wdata[`WTG_MODE_STOP_BIT])
               wdt_mode_reg_r <= reg_wdata;
         end
      end
   end

   // Pending reset request is held until the source clock runs again.
   always @(posedge mclk)
   begin
      if (!reset_n)
      begin
         pend_r    <= 1'b0;
         wdt_reset <= 1'b0;
      end
      else if (ce)
      begin
         if (cause)
            pend_r <= 1'b1;
         if ((pend_r || cause) && src_run)
            wdt_reset <= 1'b1;
      end
   end

   // Counter advances only on source ticks while the source runs.
   wtg_counter #(
      .CNT_W    (CNT_W),
      .SEL_BASE (`WTG_SEL_BASE)
   ) u_cnt (
      .mclk    (mclk),
      .reset_n (reset_n),
      .ce      (ce),
      .advance (osc_tick && src_run),
      .clear   (key_wr && !key_bad),
      .sel     (sel),
      .ovf     (ovf),
      .count   (wdt_count)
   );

   // Sticky status, write one to clear; a new event wins over the clear.
   always @*
   begin
      sts_nxt = sts_r;
      if (reg_wr && hit(reg_addr, `WTG_ADDR_IRQ_STS))
         sts_nxt = sts_nxt & ~reg_wdata[`WTG_IRQ_W-1:0];
      sts_nxt = sts_nxt | ev;
   end

   always @(posedge mclk)
   begin
      if (!reset_n)
      begin
         sts_r  <= {`WTG_IRQ_W{1'b0}};
         mask_r <= {`WTG_IRQ_W{1'b0}};
      end
      else if (ce)
      begin
         sts_r <= sts_nxt;
         if (reg_wr && hit(reg_addr, `WTG_ADDR_IRQ_MASK))
            mask_r <= reg_wdata[`WTG_IRQ_W-1:0];
      end
   end

   assign irq = |(sts_r & mask_r);

   // Read data stands in the cycle after the strobe only.
   always @(posedge mclk)
   begin
      if (!reset_n)
         reg_rdata <= 8'h00;
      else if (ce)
      begin
         reg_rdata <= 8'h00;
         if (reg_rd)
         begin
            if (hit(reg_addr, `WTG_ADDR_MODE))
               reg_rdata <= wdt_mode_reg_r;
            else if (hit(reg_addr, `WTG_ADDR_KEY))
               reg_rdata <= `WTG_KEY_READBACK;
            else if (hit(reg_addr, `WTG_ADDR_IRQ_STS))
               reg_rdata <= {{(8-`WTG_IRQ_W){1'b0}}, sts_r};
            else if (hit(reg_addr, `WTG_ADDR_IRQ_MASK))
               reg_rdata <= {{(8-`WTG_IRQ_W){1'b0}}, mask_r};
         end
      end
   end

endmodule

// ===== verif/wtg_props.sv
`timescale 1ns/1ps
`include "wtg_consts.vh"

// Checks reset causes, key readback and counting at the ports.
module wtg_props #(
   parameter CNT_W = 17
) (
   input wire                   mclk,          // Clock.
   input wire                   reset_n,       // Reset, active low.
   input wire                   ce,            // Clock enable.
   input wire [`WTG_ADDR_W-1:0] reg_addr,      // Address.
   input wire [7:0]             reg_wdata,     // Write data.
   input wire                   reg_wr,        // Write strobe.
   input wire                   reg_bitop,     // Bit strobe.
   input wire                   reg_rd,        // Read strobe.
   input wire [7:0]             reg_rdata,     // Read data.
   input wire                   opt_stoppable, // Option strap.
   input wire                   osc_tick,      // Source tick.
   input wire                   cpu_halt,      // HALT.
   input wire                   cpu_stop,      // STOP.
   input wire                   wdt_reset,     // Reset request.
   input wire                   irq,           // Interrupt.
   input wire [CNT_W-1:0]       wdt_count      // Count.
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!reset_n);
   // A key register write taken this cycle.
   wire kw = ce && reg_wr && reg_addr == `WTG_ADDR_KEY;
   a_key_bad: assert property (kw && reg_wdata != `WTG_KEY_VALUE && !opt_stoppable |=> wdt_reset)
      else $error("bad key gave no reset");
   a_key_read: assert property (ce && reg_rd && reg_addr == `WTG_ADDR_KEY |=> reg_rdata == `WTG_KEY_READBACK)
      else $error("key readback wrong");
   a_key_clear: assert property (kw && reg_wdata == `WTG_KEY_VALUE |=> wdt_count == 0)
      else $error("key write did not clear count");
   a_bitop_rst: assert property (ce && reg_bitop && reg_addr == `WTG_ADDR_KEY && !opt_stoppable |=> wdt_reset)
      else $error("bit access gave no reset");
   a_reset_holds: assert property (wdt_reset |=> wdt_reset)
      else $error("reset request dropped");
   a_halt_freeze: assert property (ce && opt_stoppable && (cpu_halt || cpu_stop) && !kw |=> $stable(wdt_count))
      else $error("count moved while halted");
   a_fixed_runs: assert property (ce && !opt_stoppable && osc_tick && !kw && !wdt_reset |=> wdt_count != $past(wdt_count))
      else $error("count did not advance");
   a_ovf_rst: assert property (!opt_stoppable && wdt_count == 0 && $past(wdt_count) != 0 && $past(osc_tick) && !$past(reg_wr) |-> ##[1:2] wdt_reset)
      else $error("overflow gave no reset");
   c_key: cover property (kw && reg_wdata == `WTG_KEY_VALUE);
   c_rst: cover property ($rose(wdt_reset));
   c_halt: cover property (opt_stoppable && cpu_halt && osc_tick);
endmodule

bind wtg_top wtg_props #(.CNT_W(CNT_W)) u_wtg_props (.mclk(mclk), .reset_n(reset_n), .ce(ce),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_bitop(reg_bitop),
   .reg_rd(reg_rd), .reg_rdata(reg_rdata), .opt_stoppable(opt_stoppable),
   .osc_tick(osc_tick), .cpu_halt(cpu_halt), .cpu_stop(cpu_stop),
   .wdt_reset(wdt_reset), .irq(irq), .wdt_count(wdt_count));

// ===== verif/wtg_top_tb.sv
`timescale 1ns/1ps

module wtg_top_tb;
   reg          mclk, reset_n, ce, reg_wr, reg_bitop, reg_rd;
   reg          opt_stoppable, osc_tick, cpu_halt, cpu_stop;
   reg  [3:0]   reg_addr;
   reg  [7:0]   reg_wdata;
   wire [7:0]   reg_rdata;
   wire         wdt_reset, irq;
   wire [16:0]  wdt_count;
   integer      bad_count, n_tests, cyc, i;

   wtg_top #(.CNT_W(17)) u_wtg_top (.mclk(mclk), .reset_n(reset_n), .ce(ce),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_bitop(reg_bitop),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .opt_stoppable(opt_stoppable),
      .osc_tick(osc_tick), .cpu_halt(cpu_halt), .cpu_stop(cpu_stop),
      .wdt_reset(wdt_reset), .irq(irq), .wdt_count(wdt_count));

   // Compares a seen value with the expected one.
   task chk(input logic [31:0] v, input logic [31:0] e);
      begin
         n_tests = n_tests + 1;
         if (v !== e)
         begin
            bad_count = bad_count + 1;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, v, e);
         end
      end
   endtask

   // Prints the verdict and ends the run.
   task final_report;
      begin
         if (bad_count == 0 && n_tests > 0)
            $display("No errors found");
         else
            $display("Errors were found");
         $finish;
      end
   endtask

   // One write or bit access, then settles past the taking edge.
   task wr(input [3:0] a, input [7:0] d, input b);
      begin
         @(posedge mclk);
         reg_addr <= a;
         reg_wdata <= d;
         reg_wr <= !b;
         reg_bitop <= b;
         @(posedge mclk);
         reg_wr <= 1'b0;
         reg_bitop <= 1'b0;
         #1;
      end
   endtask

   // One read, with the data checked in the cycle after the strobe.
   task rd(input [3:0] a, input [7:0] e);
      begin
         @(posedge mclk);
         reg_addr <= a;
         reg_rd <= 1'b1;
         @(posedge mclk);
         reg_rd <= 1'b0;
         #1;
         chk(reg_rdata, e);
      end
   endtask

   // Gives n source ticks on consecutive cycles.
   task tk(input integer n);
      begin
         @(posedge mclk);
         osc_tick <= 1'b1;
         repeat (n) @(posedge mclk);
         osc_tick <= 1'b0;
         #1;
      end
   endtask

   // Resets for 16 cycles with the given option strap.
   task rs(input o);
      begin
         reset_n <= 1'b0;
         opt_stoppable <= o;
         cpu_halt <= 1'b0;
         cpu_stop <= 1'b0;
         repeat (16) @(posedge mclk);
         reset_n <= 1'b1;
         repeat (2) @(posedge mclk);
         #1;
      end
   endtask

   // Clock and hang guard.
   initial
   begin
      mclk = 1'b0;
      cyc = 0;
      forever #5 mclk = ~mclk;
   end
   always @(posedge mclk)
   begin
      cyc = cyc + 1;
      if (cyc == 6000)
      begin
         bad_count = bad_count + 1;
         final_report;
      end
   end

   // Main sequence: fixed option first, then the stoppable option.
   initial
   begin
      {reset_n, reg_wr, reg_bitop, reg_rd, opt_stoppable, osc_tick} = 6'h00;
      {cpu_halt, cpu_stop, reg_addr, reg_wdata} = 14'h0000;
      ce = 1'b1;
      bad_count = 0;
      n_tests = 0;
      rs(1'b0);
      rd(4'h1, 8'h9A);
      rd(4'h5, 8'h00);
      wr(4'h3, 8'h01, 1'b0);
      wr(4'h0, 8'h60, 1'b0);
      cpu_stop <= 1'b1;
      tk(5);
      chk(wdt_count, 5);
      wr(4'h1, 8'hAC, 1'b0);
      chk(wdt_count, 0);
      tk(1023);
      chk(wdt_reset, 0);
      tk(1);
      repeat (3) @(posedge mclk);
      #1;
      chk(wdt_reset, 1);
      chk(irq, 1);
      wr(4'h2, 8'h01, 1'b0);
      chk(irq, 0);
      // Bad key, bit access on the key, second mode write.
      for (i = 0; i < 3; i = i + 1)
      begin
         rs(1'b0);
         if (i == 2)
            wr(4'h0, 8'h60, 1'b0);
         wr(i == 2 ? 4'h0 : 4'h1, 8'h60, i == 1);
         chk(wdt_reset, 1);
         rd(4'h2, 8'h02 << i);
      end
      rs(1'b1);
      wr(4'h0, 8'h60, 1'b0);
      cpu_halt <= 1'b1;
      tk(5);
      chk(wdt_count, 0);
      cpu_halt <= 1'b0;
      tk(5);
      cpu_stop <= 1'b1;
      tk(5);
      chk(wdt_count, 5);
      cpu_stop <= 1'b0;
      tk(3);
      chk(wdt_count, 8);
      cpu_halt <= 1'b1;
      wr(4'h1, 8'h55, 1'b0);
      chk(wdt_reset, 0);
      cpu_halt <= 1'b0;
      repeat (3) @(posedge mclk);
      #1;
      chk(wdt_reset, 1);
      rs(1'b1);
      wr(4'h0, 8'h70, 1'b0);
      wr(4'h0, 8'h60, 1'b0);
      tk(5);
      chk(wdt_count, 0);
      chk(wdt_reset, 0);
      final_report;
   end
endmodule
